// >>> abx_defs.svh
`ifndef ABX_DEFS_SVH
`define ABX_DEFS_SVH

// operand and data widths
`define ABX_DATA_W    8
`define ABX_ADDR_W    7
`define ABX_BITIDX_W  3
`define ABX_OFS_W     9
`define ABX_PTR_W     15

// field positions inside a data byte
`define ABX_SIGN_POS  7
`define ABX_NIB_POS   4

// destination-select encodings
`define ABX_DEST_ACCUM 1'b0
`define ABX_DEST_MEM   1'b1

// reset values
`define ABX_ACC_RST   8'h00
`define ABX_FLAG_RST  1'b0
`define ABX_PTR_RST   15'h0000
`define ABX_DATA_ZERO 8'h00

// instruction cycle counts
`define ABX_JUMP_CYCLES 2
`define ABX_SKIP_CYCLES 2

`endif

// >>> abx_pkg.sv
`include "abx_defs.svh"

package abx_pkg;

  typedef enum logic [6:0] {
    OP_NOP                = 7'h01,
    OP_ADD_ACCUM_MEM      = 7'h02,
    OP_ADD_WITH_CARRY_MEM = 7'h04,
    OP_SHIFT_RIGHT_ARITH  = 7'h08,
    OP_CLEAR_MEM_BIT      = 7'h10,
    OP_TEST_SKIP_IF_ZERO  = 7'h20,
    OP_RELATIVE_JUMP      = 7'h40
  } abx_op_t;

  typedef enum logic [2:0] {
    ST_EXEC = 3'h1,
    ST_WAIT = 3'h2,
    ST_SKIP = 3'h4
  } abx_state_t;

endpackage

// >>> abx_alu_if.sv
`include "abx_defs.svh"

interface abx_alu_if;
  abx_pkg::abx_op_t              op;
  logic [`ABX_DATA_W-1:0]        accum;
  logic [`ABX_DATA_W-1:0]        operand;
  logic                          carryIn;
  logic [`ABX_BITIDX_W-1:0]      bitIndex;
  logic [`ABX_DATA_W-1:0]        result;
  logic                          carryOut;
  logic                          nibbleOut;
  logic                          zeroOut;
  logic                          updCarry;
  logic                          updNibble;
  logic                          updZero;
  logic                          writesResult;
  logic                          skipNext;

  modport core (
    output op, accum, operand, carryIn, bitIndex,
    input  result, carryOut, nibbleOut, zeroOut, updCarry, updNibble, updZero,
    input  writesResult, skipNext
  );

  modport alu (
    input  op, accum, operand, carryIn, bitIndex,
    output result, carryOut, nibbleOut, zeroOut, updCarry, updNibble, updZero,
    output writesResult, skipNext
  );
endinterface

// >>> abx_alu.sv
`include "abx_defs.svh"

module abx_alu (
  abx_alu_if.alu bus
);

  // returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [`ABX_DATA_W+1:0] addFlags(
    input logic [`ABX_DATA_W-1:0] a,
    input logic [`ABX_DATA_W-1:0] b,
    input logic                   ci
  );
    logic [`ABX_NIB_POS:0] lo;
    logic [`ABX_DATA_W:0]  full;
    lo   = {1'b0, a[`ABX_NIB_POS-1:0]} + {1'b0, b[`ABX_NIB_POS-1:0]} + {4'h0, ci};
    full = {1'b0, a} + {1'b0, b} + {8'h00, ci};
    return {full[`ABX_DATA_W], lo[`ABX_NIB_POS], full[`ABX_DATA_W-1:0]};
  endfunction

  wire isAdd   = (bus.op == abx_pkg::OP_ADD_ACCUM_MEM);
  wire isAdc   = (bus.op == abx_pkg::OP_ADD_WITH_CARRY_MEM);
  wire isShift = (bus.op == abx_pkg::OP_SHIFT_RIGHT_ARITH);
  wire isClr   = (bus.op == abx_pkg::OP_CLEAR_MEM_BIT);
  wire isSkip  = (bus.op == abx_pkg::OP_TEST_SKIP_IF_ZERO);

  wire [`ABX_DATA_W+1:0] addRes = addFlags(bus.accum, bus.operand, 1'b0);
  wire [`ABX_DATA_W+1:0] adcRes = addFlags(bus.accum, bus.operand, bus.carryIn);
  wire [`ABX_DATA_W-1:0] shiftRes =
    {bus.operand[`ABX_SIGN_POS], bus.operand[`ABX_DATA_W-1:1]};
  wire [`ABX_DATA_W-1:0] clearMask = ~(8'h01 << bus.bitIndex);
  wire [`ABX_DATA_W-1:0] clearRes  = bus.operand & clearMask;

  assign bus.result = isAdd   ? addRes[`ABX_DATA_W-1:0] :
                      isAdc   ? adcRes[`ABX_DATA_W-1:0] :
                      isShift ? shiftRes :
                      isClr   ? clearRes : `ABX_DATA_ZERO;

  // carry out of bit 7, nibble carry out of bit 3, zero on 8-bit result
  assign bus.carryOut  = isAdd   ? addRes[`ABX_DATA_W+1] :
                         isAdc   ? adcRes[`ABX_DATA_W+1] :
                         isShift ? bus.operand[0] : bus.carryIn;
  assign bus.nibbleOut = isAdd ? addRes[`ABX_DATA_W] : adcRes[`ABX_DATA_W];
  assign bus.zeroOut   = (bus.result == `ABX_DATA_ZERO);

  assign bus.updCarry     = isAdd | isAdc | isShift;
  assign bus.updNibble    = isAdd | isAdc;
  assign bus.updZero      = isAdd | isAdc | isShift;
  assign bus.writesResult = isAdd | isAdc | isShift | isClr;
  assign bus.skipNext     = isSkip & ~bus.operand[bus.bitIndex];

endmodule

// >>> abx_exec.sv
`include "abx_defs.svh"

// Overview of operation
// - Add accumulator and addressed byte (address 0..127), updating carry, nibble and zero.
// - Destination select 0 writes the accumulator, 1 writes the addressed memory byte.
// - Arithmetic right shift moves bits 7:1 to 6:0, keeps bit 7, puts bit 0 into carry.
// - The shift updates only carry and zero and writes to the selected destination.
// - Add-with-carry sums accumulator, memory byte and carry, updates carry, nibble, zero.
// - Bit clear zeroes the selected bit 0..7 of memory and leaves flags untouched.
// - Test-skip runs the next instruction if the bit is one, else turns it into a nop.
// - Relative jump target is pointer plus one plus a signed 9-bit offset (-256..255).
// - Relative jump always takes two cycles and leaves every flag unchanged.
// - An operand through the indirect port costs one extra cycle when pointer MSB is set.
module abx_exec #(
  parameter int PTR_W = `ABX_PTR_W
) (
  input  wire logic                     sys_clk,
  input  wire logic                     sys_rst,
  input  wire logic                     instrValid,
  output logic                          instrReady,
  input  wire abx_pkg::abx_op_t         instrOp,
  input  wire logic [`ABX_ADDR_W-1:0]   instrAddr,
  input  wire logic                     instrDest,
  input  wire logic [`ABX_BITIDX_W-1:0] instrBit,
  input  wire logic [`ABX_OFS_W-1:0]    instrOffset,
  input  wire logic                     indirectSel,
  input  wire logic                     pointerMsb,
  output logic [`ABX_ADDR_W-1:0]        memAddr,
  input  wire logic [`ABX_DATA_W-1:0]   memRdData,
  output logic                          memWe,
  output logic [`ABX_ADDR_W-1:0]        memWrAddr,
  output logic [`ABX_DATA_W-1:0]        memWrData,
  output logic [`ABX_DATA_W-1:0]        accum,
  output logic                          carryFlag,
  output logic                          nibbleOverflowBit,
  output logic                          zeroFlag,
  output logic [PTR_W-1:0]              instrPointer,
  output logic                          discardPulse
);

  abx_alu_if aluBus ();

  abx_alu u_alu (
    .bus (aluBus.alu)
  );

  abx_pkg::abx_state_t state;
  abx_pkg::abx_state_t next_state;
  logic                pendingSkip;

  assign aluBus.op       = instrOp;
  assign aluBus.accum    = accum;
  assign aluBus.operand  = memRdData;
  assign aluBus.carryIn  = carryFlag;
  assign aluBus.bitIndex = instrBit;

  // request decode
  assign instrReady = (state != abx_pkg::ST_WAIT);
  assign memAddr    = instrAddr;

  wire take    = instrValid & instrReady;
  wire live    = take & (state == abx_pkg::ST_EXEC);
  wire discard = take & (state == abx_pkg::ST_SKIP);
  wire isJump  = (instrOp == abx_pkg::OP_RELATIVE_JUMP);
  wire isClr   = (instrOp == abx_pkg::OP_CLEAR_MEM_BIT);
  wire hasOperand = ~isJump & (instrOp != abx_pkg::OP_NOP);
  wire extraInd   = live & hasOperand & indirectSel & pointerMsb;
  wire doJump     = live & isJump;
  wire doSkip     = live & aluBus.skipNext;

  // result routing
  wire toMem   = isClr | (instrDest == `ABX_DEST_MEM);
  wire wrAccum = live & aluBus.writesResult & ~toMem;
  wire wrMem   = live & aluBus.writesResult & toMem;

  // pointer arithmetic
  wire [PTR_W-1:0] ptrOffset = PTR_W'($signed(instrOffset));
  wire [PTR_W-1:0] ptrInc    = instrPointer + PTR_W'(1);
  wire [PTR_W-1:0] next_instrPointer =
    doJump ? ptrInc + ptrOffset :
    take   ? ptrInc : instrPointer;

  wire [`ABX_DATA_W-1:0] next_accum = wrAccum ? aluBus.result : accum;
  wire next_carry  = (live & aluBus.updCarry)  ? aluBus.carryOut  : carryFlag;
  wire next_nibble = (live & aluBus.updNibble) ? aluBus.nibbleOut : nibbleOverflowBit;
  wire next_zero   = (live & aluBus.updZero)   ? aluBus.zeroOut   : zeroFlag;

  // sequencing: jump and indirect stall through wait, skip discards one slot
  always_comb begin
    next_state = state;
    case (state)
      abx_pkg::ST_EXEC: begin
        if (doJump || extraInd) begin
          next_state = abx_pkg::ST_WAIT;
        end else if (doSkip) begin
          next_state = abx_pkg::ST_SKIP;
        end
      end
      abx_pkg::ST_WAIT: begin
        next_state = pendingSkip ? abx_pkg::ST_SKIP : abx_pkg::ST_EXEC;
      end
      abx_pkg::ST_SKIP: begin
        if (take) begin
          next_state = abx_pkg::ST_EXEC;
        end
      end
      default: begin
        next_state = abx_pkg::ST_EXEC;
      end
    endcase
  end

  wire next_pendingSkip = (state == abx_pkg::ST_EXEC) ? (extraInd & doSkip) : 1'b0;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state        <= abx_pkg::ST_EXEC;
      pendingSkip  <= 1'b0;
      instrPointer <= PTR_W'(`ABX_PTR_RST);
    end else begin
      state        <= next_state;
      pendingSkip  <= next_pendingSkip;
      instrPointer <= next_instrPointer;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      accum             <= `ABX_ACC_RST;
      carryFlag         <= `ABX_FLAG_RST;
      nibbleOverflowBit <= `ABX_FLAG_RST;
      zeroFlag          <= `ABX_FLAG_RST;
    end else begin
      accum             <= next_accum;
      carryFlag         <= next_carry;
      nibbleOverflowBit <= next_nibble;
      zeroFlag          <= next_zero;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      memWe        <= 1'b0;
      memWrAddr    <= '0;
      memWrData    <= `ABX_DATA_ZERO;
      discardPulse <= 1'b0;
    end else begin
      memWe        <= wrMem;
      memWrAddr    <= wrMem ? instrAddr : memWrAddr;
      memWrData    <= wrMem ? aluBus.result : memWrData;
      discardPulse <= discard;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_add_accum_sum: assert property (
    live && instrOp == abx_pkg::OP_ADD_ACCUM_MEM && instrDest == `ABX_DEST_ACCUM
    |=> accum == 8'($past(accum) + $past(memRdData)) && !memWe)
    else $error("add to accumulator gave wrong sum");

  a_add_carry_out: assert property (
    live && instrOp == abx_pkg::OP_ADD_ACCUM_MEM
    |=> carryFlag == (({1'b0, $past(accum)} + {1'b0, $past(memRdData)}) > 9'h0FF)
        && zeroFlag == (8'($past(accum) + $past(memRdData)) == `ABX_DATA_ZERO))
    else $error("add flags wrong");

  a_adc_mem_dest: assert property (
    live && instrOp == abx_pkg::OP_ADD_WITH_CARRY_MEM && instrDest == `ABX_DEST_MEM
    |=> memWe && $stable(accum)
        && memWrData == 8'($past(accum) + $past(memRdData) + {7'h00, $past(carryFlag)}))
    else $error("add with carry to memory wrong");

  a_shift_flags: assert property (
    live && instrOp == abx_pkg::OP_SHIFT_RIGHT_ARITH
    |=> carryFlag == $past(memRdData[0]) && $stable(nibbleOverflowBit))
    else $error("shift flags wrong");

  a_clear_bit_only: assert property (
    live && isClr
    |=> memWe && memWrData == ($past(memRdData) & ~(8'h01 << $past(instrBit)))
        && $stable({carryFlag, nibbleOverflowBit, zeroFlag}))
    else $error("bit clear wrong");

  a_skip_on_zero: assert property (
    live && !extraInd && instrOp == abx_pkg::OP_TEST_SKIP_IF_ZERO
    |=> (state == abx_pkg::ST_SKIP) == !$past(memRdData[instrBit]))
    else $error("skip decision wrong");

  a_skip_no_effect: assert property (
    discard |=> !memWe && $stable(accum) && $stable({carryFlag, nibbleOverflowBit, zeroFlag})
        && state == abx_pkg::ST_EXEC)
    else $error("skipped instruction had an effect");

  a_jump_target: assert property (
    doJump |=> instrPointer == $past(instrPointer) + PTR_W'(1) + $past(ptrOffset))
    else $error("jump target wrong");

  a_jump_two_cycle: assert property (
    doJump |=> !instrReady && $stable({carryFlag, nibbleOverflowBit, zeroFlag})
        ##1 instrReady)
    else $error("jump timing or flags wrong");

  a_indirect_stall: assert property (
    extraInd |=> !instrReady ##1 instrReady)
    else $error("indirect stall missing");

  a_indirect_skip_order: assert property (
    extraInd && doSkip |=> !instrReady ##1 (instrReady && state == abx_pkg::ST_SKIP))
    else $error("indirect skip order wrong");

  a_dest_mem_route: assert property (
    live && aluBus.writesResult && !isClr && instrDest == `ABX_DEST_MEM
    |=> memWe && $stable(accum))
    else $error("memory destination routing wrong");

  c_jump:     cover property (doJump ##2 take);
  c_skip:     cover property (doSkip ##1 discard);
  c_indirect: cover property (extraInd && aluBus.skipNext);
  c_adc:      cover property (live && instrOp == abx_pkg::OP_ADD_WITH_CARRY_MEM && carryFlag);

endmodule

// >>> abx_exec_tb.sv
`include "abx_defs.svh"

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic                     sys_clk;
  logic                     sys_rst;
  logic                     instrValid;
  logic                     instrReady;
  abx_pkg::abx_op_t         instrOp;
  logic [`ABX_ADDR_W-1:0]   instrAddr;
  logic                     instrDest;
  logic [`ABX_BITIDX_W-1:0] instrBit;
  logic [`ABX_OFS_W-1:0]    instrOffset;
  logic                     indirectSel;
  logic                     pointerMsb;
  logic [`ABX_ADDR_W-1:0]   memAddr;
  logic [`ABX_DATA_W-1:0]   memRdData;
  logic                     memWe;
  logic [`ABX_ADDR_W-1:0]   memWrAddr;
  logic [`ABX_DATA_W-1:0]   memWrData;
  logic [`ABX_DATA_W-1:0]   accum;
  logic                     carryFlag;
  logic                     nibbleOverflowBit;
  logic                     zeroFlag;
  logic [14:0]              instrPointer;
  logic                     discardPulse;
  logic [7:0]               mem [0:127];
  int                       nFail;
  int                       totalChecks;

  abx_exec dut_u (
    .sys_clk           (sys_clk),
    .sys_rst           (sys_rst),
    .instrValid        (instrValid),
    .instrReady        (instrReady),
    .instrOp           (instrOp),
    .instrAddr         (instrAddr),
    .instrDest         (instrDest),
    .instrBit          (instrBit),
    .instrOffset       (instrOffset),
    .indirectSel       (indirectSel),
    .pointerMsb        (pointerMsb),
    .memAddr           (memAddr),
    .memRdData         (memRdData),
    .memWe             (memWe),
    .memWrAddr         (memWrAddr),
    .memWrData         (memWrData),
    .accum             (accum),
    .carryFlag         (carryFlag),
    .nibbleOverflowBit (nibbleOverflowBit),
    .zeroFlag          (zeroFlag),
    .instrPointer      (instrPointer),
    .discardPulse      (discardPulse)
  );

  // combinational data memory beside the core
  assign memRdData = mem[memAddr];
  always @(posedge sys_clk) if (memWe === 1'b1) mem[memWrAddr] <= memWrData;
  always #5 sys_clk = ~sys_clk;

  task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic chkFlags(logic c, logic dc, logic z);
    chk("carry", {15'h0, carryFlag}, {15'h0, c});
    chk("nibble", {15'h0, nibbleOverflowBit}, {15'h0, dc});
    chk("zero", {15'h0, zeroFlag}, {15'h0, z});
  endtask

  task automatic chkWrite(logic [6:0] a, logic [7:0] d);
    chk("memWe", {15'h0, memWe}, 16'h0001);
    chk("memWrAddr", {9'h0, memWrAddr}, {9'h0, a});
    chk("memWrData", {8'h0, memWrData}, {8'h0, d});
  endtask

  task automatic finalReport();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // let edges pass until ready (at least one), offer one instruction and hold it until the edge that takes it
  task automatic issue(abx_pkg::abx_op_t op, logic [6:0] a, logic d, logic [2:0] bi = 3'h0,
                       logic [8:0] ofs = 9'h000, logic ind = 1'b0, logic msb = 1'b0);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (instrReady !== 1'b1 && n < 8);
    if (instrReady !== 1'b1) begin
      nFail++;
      finalReport();
    end
    instrValid = 1'b1;
    instrOp = op;
    instrAddr = a;
    instrDest = d;
    instrBit = bi;
    instrOffset = ofs;
    indirectSel = ind;
    pointerMsb = msb;
    @(posedge sys_clk);
    #1;
    instrValid = 1'b0;
    instrOp = abx_pkg::OP_NOP;
    indirectSel = 1'b0;
  endtask

  task automatic t_add();
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b0);
    chk("accum", {8'h0, accum}, 16'h00F8);
    chk("memAddr", {9'h0, memAddr}, 16'h0005);
    chkFlags(1'b0, 1'b0, 1'b0);
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h06, 1'b1);
    chkWrite(7'h06, 8'h10);
    chk("accum", {8'h0, accum}, 16'h00F8);
    chkFlags(1'b1, 1'b1, 1'b0);
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h7F, 1'b1);
    chkWrite(7'h7F, 8'h1D);
    chkFlags(1'b1, 1'b0, 1'b0);
    $display("test add done");
  endtask

  task automatic t_addc();
    issue(abx_pkg::OP_ADD_WITH_CARRY_MEM, 7'h0C, 1'b1);
    chkWrite(7'h0C, 8'h2C);
    chkFlags(1'b1, 1'b0, 1'b0);
    issue(abx_pkg::OP_ADD_WITH_CARRY_MEM, 7'h07, 1'b0);
    chk("accum", {8'h0, accum}, 16'h0000);
    chkFlags(1'b1, 1'b1, 1'b1);
    $display("test addc done");
  endtask

  task automatic t_shift();
    issue(abx_pkg::OP_SHIFT_RIGHT_ARITH, 7'h08, 1'b1);
    chkWrite(7'h08, 8'hC0);
    chk("accum", {8'h0, accum}, 16'h0000);
    chkFlags(1'b1, 1'b1, 1'b0);
    issue(abx_pkg::OP_SHIFT_RIGHT_ARITH, 7'h09, 1'b0);
    chk("accum", {8'h0, accum}, 16'h0000);
    chk("memWe", {15'h0, memWe}, 16'h0000);
    chkFlags(1'b1, 1'b1, 1'b1);
    $display("test shift done");
  endtask

  task automatic t_clr();
    for (int b = 0; b < 8; b++) begin
      @(posedge sys_clk);
      #1;
      mem[10] = 8'hFF;
      issue(abx_pkg::OP_CLEAR_MEM_BIT, 7'h0A, 1'b0, b[2:0]);
      chkWrite(7'h0A, 8'hFF & ~(8'h01 << b));
      chkFlags(1'b1, 1'b1, 1'b1);
    end
    $display("test clear done");
  endtask

  task automatic t_skip();
    logic [14:0] p;
    issue(abx_pkg::OP_TEST_SKIP_IF_ZERO, 7'h0B, 1'b0, 3'h1);
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b0);
    chk("accum", {8'h0, accum}, 16'h00F8);
    chkFlags(1'b0, 1'b0, 1'b0);
    issue(abx_pkg::OP_TEST_SKIP_IF_ZERO, 7'h0B, 1'b0, 3'h0);
    p = instrPointer;
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b1);
    chk("memWe", {15'h0, memWe}, 16'h0000);
    chk("accum", {8'h0, accum}, 16'h00F8);
    chkFlags(1'b0, 1'b0, 1'b0);
    chk("pointer", {1'b0, instrPointer}, {1'b0, p + 15'h0001});
    chk("discard", {15'h0, discardPulse}, 16'h0001);
    $display("test skip done");
  endtask

  task automatic t_jump();
    logic [8:0]  ofs [2];
    logic [14:0] p;
    ofs[0] = 9'h100;
    ofs[1] = 9'h0FF;
    for (int i = 0; i < 2; i++) begin
      p = instrPointer;
      issue(abx_pkg::OP_RELATIVE_JUMP, 7'h00, 1'b0, 3'h0, ofs[i]);
      chk("pointer", {1'b0, instrPointer},
          {1'b0, p + 15'h0001 + {{6{ofs[i][8]}}, ofs[i]}});
      chk("ready", {15'h0, instrReady}, 16'h0000);
      chkFlags(1'b0, 1'b0, 1'b0);
      @(posedge sys_clk);
      #1;
      chk("ready", {15'h0, instrReady}, 16'h0001);
    end
    $display("test jump done");
  endtask

  task automatic t_indirect();
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b0, 3'h0, 9'h000, 1'b1, 1'b1);
    chk("accum", {8'h0, accum}, 16'h00F0);
    chk("ready", {15'h0, instrReady}, 16'h0000);
    @(posedge sys_clk);
    #1;
    chk("ready", {15'h0, instrReady}, 16'h0001);
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b0, 3'h0, 9'h000, 1'b1, 1'b0);
    chk("ready", {15'h0, instrReady}, 16'h0001);
    issue(abx_pkg::OP_TEST_SKIP_IF_ZERO, 7'h0B, 1'b0, 3'h0, 9'h000, 1'b1, 1'b1);
    chk("ready", {15'h0, instrReady}, 16'h0000);
    issue(abx_pkg::OP_ADD_ACCUM_MEM, 7'h05, 1'b0);
    chk("accum", {8'h0, accum}, 16'h00E8);
    chk("discard", {15'h0, discardPulse}, 16'h0001);
    $display("test indirect done");
  endtask

  initial begin
    #200000;
    nFail++;
    finalReport();
  end

  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    instrValid = 1'b0;
    instrOp = abx_pkg::OP_NOP;
    instrAddr = 7'h00;
    instrDest = 1'b0;
    instrBit = 3'h0;
    instrOffset = 9'h000;
    indirectSel = 1'b0;
    pointerMsb = 1'b0;
    nFail = 0;
    totalChecks = 0;
    for (int i = 0; i < 128; i++) mem[i] = i[7:0] ^ 8'h5A;
    mem[5] = 8'hF8;
    mem[6] = 8'h18;
    mem[7] = 8'h07;
    mem[8] = 8'h81;
    mem[9] = 8'h01;
    mem[11] = 8'hFE;
    mem[12] = 8'h33;
    repeat (16) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    chk("accum", {8'h0, accum}, 16'h0000);
    chkFlags(1'b0, 1'b0, 1'b0);
    chk("pointer", {1'b0, instrPointer}, 16'h0000);
    t_add();
    t_addc();
    t_shift();
    t_clr();
    t_skip();
    t_jump();
    t_indirect();
    finalReport();
  end
endmodule
